// File: hw/polrpm_pkg.sv
/*
 * Constants, register map and state type of the ramp and protection manager.
 * Assumes a 20 MHz system clock and voltages coded in 12.5 mV units.
 */
package polrpm_pkg;
	localparam int CLK_HZ = 20000000;
	localparam int HICCUP_MS = 130;
	localparam logic [21:0] HICCUP_CYC = 22'(CLK_HZ / 1000 * HICCUP_MS);
	localparam int STEP_UV = 12500;
	localparam int TRACK_MV = 250;
	localparam logic [15:0] TRACK_CODES = 16'(TRACK_MV * 1000 / STEP_UV);
	localparam int OV_FLOOR_MV = 1000;
	localparam logic [15:0] OV_FLOOR = 16'(OV_FLOOR_MV * 1000 / STEP_UV);
	localparam int OTW_SET_C = 120;
	localparam int OTW_CLR_C = 117;
	localparam int OT_FAULT_C = 130;
	localparam int ROOM_C = 25;
	localparam int OC_COMP_SHIFT = 3;
	localparam int PCT_FULL = 100;
	localparam int PG_HI_PCT = 110;
	localparam int PG_LO_PCT = 90;
	localparam int PG_LO_ALT_PCT = 95;
	localparam int OV_MIN_PCT = 110;
	localparam int OV_MAX_PCT = 130;
	// Register indexes; byte address is index times four
	localparam logic [5:0] IDX_FMODE = 6'h00;
	localparam logic [5:0] IDX_THR = 6'h01;
	localparam logic [5:0] IDX_REP = 6'h02;
	localparam logic [5:0] IDX_SLEW = 6'h03;
	localparam logic [5:0] IDX_SET = 6'h07;
	localparam logic [5:0] IDX_CLS = 6'h08;
	localparam logic [5:0] IDX_RUN = 6'h15;
	localparam logic [5:0] IDX_STAT = 6'h16;
	localparam logic [5:0] IDX_VOM = 6'h17;
	localparam logic [5:0] IDX_TMP = 6'h19;
	// Status bit positions, all active low
	localparam int SB_OTW = 0;
	localparam int SB_PG = 1;
	localparam int SB_OC = 2;
	localparam int SB_UV = 3;
	localparam int SB_OT = 4;
	localparam int SB_TR = 5;
	localparam int SB_OV = 6;
	localparam int FM_TR_DIS = 7;
	localparam int TH_PGLO_SEL = 0;
	localparam int TH_OV_LSB = 8;
	localparam int TH_UV_LSB = 16;
	localparam int REP_OTW = 0;
	localparam int REP_PG = 1;
	localparam int REP_PROP = 2;
	localparam int CLS_COMP_DIS = 7;
	localparam logic [7:0] FM_RST = 8'h00;
	localparam logic [31:0] TH_RST = 32'h0050_0000;
	localparam logic [7:0] REP_RST = 8'h00;
	localparam logic [31:0] SLEW_RST = 32'h0001_0001;
	localparam logic [15:0] SET_RST = 16'h0050;
	localparam logic [7:0] CLS_RST = 8'h40;
	localparam logic [6:0] STAT_RST = 7'h7F;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {S_OFF, S_ON, S_DOWN, S_WAIT} polrpm_state_t;
endpackage : polrpm_pkg

// File: hw/polrpm_top.sv
/*
 * Ramp stepping, protection evaluation and status register of a load converter module,
 * with an AXI4-Lite register slave.
 * Assumes vout_code, temp_c, ilim_active and all pins arrive asynchronously;
 * the testbench resolves the open-drain lines from the output enables.
 */
`timescale 1ns/1ns

module polrpm_top #(
	parameter logic [21:0] HICCUP = polrpm_pkg::HICCUP_CYC
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [15:0] vout_code,
	input wire logic [7:0] temp_c,
	input wire logic ilim_active,
	input wire logic mclk_in,
	input wire logic pg_in,
	output logic pg_o,
	output logic pg_oe,
	input wire logic ok_in,
	output logic ok_o,
	output logic ok_oe,
	input wire logic err_in,
	output logic err_out,
	output logic mgr_alert,
	output logic [15:0] vref_code,
	output logic conv_en,
	output logic ls_force,
	output logic [7:0] oc_limit
);
	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	logic [28:0] s1, s2;
	logic mclk_d;
	logic [1:0] oe_d1, oe_d2;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			s1 <= 29'h0;
			s2 <= 29'h0;
			mclk_d <= 1'h0;
			oe_d1 <= 2'h0;
			oe_d2 <= 2'h0;
		end else begin
			s1 <= {err_in, ok_in, pg_in, mclk_in, ilim_active, temp_c, vout_code};
			s2 <= s1;
			mclk_d <= s2[25];
			oe_d1 <= {ok_oe, pg_oe};
			oe_d2 <= oe_d1;
		end
	end
	logic [15:0] vo;
	logic [7:0] tmp;
	logic ilim, tick, pg_s, ok_s, err_s;
	assign vo = s2[15:0];
	assign tmp = s2[23:16];
	assign ilim = s2[24];
	assign tick = s2[25] & ~mclk_d;
	assign pg_s = s2[26];
	assign ok_s = s2[27];
	assign err_s = s2[28];

	// ****************************************************************
	// Registers and bus slave
	// ****************************************************************
	polrpm_pkg::polrpm_state_t state;
	logic [7:0] fm, rep, current_limit_setpoint;
	logic [31:0] thr, slew;
	logic [15:0] setp;
	logic run;
	logic [6:0] stat;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q, wmask;
	logic do_wr, wr_map, rd_map;
	logic [5:0] widx;
	logic [31:0] rd_data;
	logic [6:0] sw_clr;

	assign widx = awaddr_q[7:2];
	assign do_wr = ~awready & ~wready & ~bvalid;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			awready <= 1'h1;
			wready <= 1'h1;
			bvalid <= 1'h0;
			bresp <= polrpm_pkg::RESP_OK;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0;
			wmask <= 32'h0;
		end else begin
			if (awvalid && awready) begin
				awaddr_q <= awaddr;
				awready <= 1'h0;
			end
			if (wvalid && wready) begin
				wdata_q <= wdata;
				wmask <= {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
				wready <= 1'h0;
			end
			if (do_wr) begin
				bvalid <= 1'h1;
				bresp <= wr_map ? polrpm_pkg::RESP_OK : polrpm_pkg::RESP_SLVERR;
			end
			if (bvalid && bready) begin
				bvalid <= 1'h0;
				awready <= 1'h1;
				wready <= 1'h1;
			end
		end
	end

	always_comb begin
		wr_map = 1'h1;
		case (widx)
			polrpm_pkg::IDX_FMODE, polrpm_pkg::IDX_THR, polrpm_pkg::IDX_REP,
			polrpm_pkg::IDX_SLEW, polrpm_pkg::IDX_SET, polrpm_pkg::IDX_CLS,
			polrpm_pkg::IDX_RUN, polrpm_pkg::IDX_STAT: wr_map = 1'h1;
			default: wr_map = 1'h0;
		endcase
	end

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [31:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			fm <= polrpm_pkg::FM_RST;
			thr <= polrpm_pkg::TH_RST;
			rep <= polrpm_pkg::REP_RST;
			slew <= polrpm_pkg::SLEW_RST;
			setp <= polrpm_pkg::SET_RST;
			current_limit_setpoint <= polrpm_pkg::CLS_RST;
			run <= 1'h0;
		end else if (do_wr) begin
			case (widx)
				polrpm_pkg::IDX_FMODE: fm <= 8'(merge(32'(fm), wdata_q, wmask));
				polrpm_pkg::IDX_THR: thr <= merge(thr, wdata_q, wmask);
				polrpm_pkg::IDX_REP: rep <= 8'(merge(32'(rep), wdata_q, wmask));
				polrpm_pkg::IDX_SLEW: slew <= merge(slew, wdata_q, wmask);
				polrpm_pkg::IDX_SET: setp <= 16'(merge(32'(setp), wdata_q, wmask));
				polrpm_pkg::IDX_CLS: current_limit_setpoint <= 8'(merge(32'(current_limit_setpoint), wdata_q, wmask));
				polrpm_pkg::IDX_RUN: run <= wmask[0] ? wdata_q[0] : run;
				default: run <= run;
			endcase
		end
	end
	assign sw_clr = (do_wr && widx == polrpm_pkg::IDX_STAT) ? (wdata_q[6:0] & wmask[6:0]) : 7'h00;

	always_comb begin
		rd_map = 1'h1;
		case (araddr[7:2])
			polrpm_pkg::IDX_FMODE: rd_data = 32'(fm);
			polrpm_pkg::IDX_THR: rd_data = thr;
			polrpm_pkg::IDX_REP: rd_data = 32'(rep);
			polrpm_pkg::IDX_SLEW: rd_data = slew;
			polrpm_pkg::IDX_SET: rd_data = 32'(setp);
			polrpm_pkg::IDX_CLS: rd_data = 32'(current_limit_setpoint);
			polrpm_pkg::IDX_RUN: rd_data = 32'(run);
			polrpm_pkg::IDX_STAT: rd_data = 32'(stat);
			polrpm_pkg::IDX_VOM: rd_data = 32'(vo);
			polrpm_pkg::IDX_TMP: rd_data = 32'(s2[23:16]);
			default: begin
				rd_data = 32'h0;
				rd_map = 1'h0;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			arready <= 1'h1;
			rvalid <= 1'h0;
			rdata <= 32'h0;
			rresp <= polrpm_pkg::RESP_OK;
		end else if (arvalid && arready) begin
			arready <= 1'h0;
			rvalid <= 1'h1;
			rdata <= rd_data;
			rresp <= rd_map ? polrpm_pkg::RESP_OK : polrpm_pkg::RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'h0;
			arready <= 1'h1;
		end
	end

	// ****************************************************************
	// Thresholds and protection events
	// ****************************************************************
	function automatic logic [31:0] pct(input logic [15:0] v, input int p);
		pct = 32'(v) * 32'(p);
	endfunction

	logic [15:0] prebias, diff;
	logic steady, ramp_up, armed, uv_low, pg_bad, pg_ext, ov_hi, ot_hot, otw_hot;
	logic fast, regular, latch_hit, go_on, hic_done, step, prop_ext, by_fault, latched;
	logic [6:2] evt;
	logic [21:0] hic_cnt;
	logic [15:0] div_cnt, cur_div;
	int ov_p;
	logic [31:0] vo_p, ov_lim, ov_floor;

	assign steady = state == polrpm_pkg::S_ON && vref_code == setp;
	assign ramp_up = state == polrpm_pkg::S_ON && vref_code < setp;
	assign armed = vo > prebias;
	assign diff = vo > vref_code ? vo - vref_code : vref_code - vo;
	assign ot_hot = tmp > polrpm_pkg::OT_FAULT_C;
	assign otw_hot = tmp >= polrpm_pkg::OTW_SET_C;
	assign pg_ext = ~pg_s & ~pg_oe & ~oe_d1[0] & ~oe_d2[0];
	assign prop_ext = ~ok_s & ~ok_oe & ~oe_d1[1] & ~oe_d2[1];

	always_comb begin
		ov_p = polrpm_pkg::OV_MIN_PCT + int'(thr[polrpm_pkg::TH_OV_LSB +: 5]);
		if (ov_p > polrpm_pkg::OV_MAX_PCT)
			ov_p = polrpm_pkg::OV_MAX_PCT;
		vo_p = pct(vo, polrpm_pkg::PCT_FULL);
		// Limits are recomputed from the live setpoint every cycle
		ov_floor = pct(polrpm_pkg::OV_FLOOR, polrpm_pkg::PCT_FULL);
		ov_lim = pct(setp, ov_p) > ov_floor ? pct(setp, ov_p) : ov_floor;
		ov_hi = vo_p > ov_lim;
		uv_low = vo_p < pct(setp, int'(thr[polrpm_pkg::TH_UV_LSB +: 7]));
		pg_bad = vo_p > pct(setp, polrpm_pkg::PG_HI_PCT) ||
			vo_p < pct(setp, thr[polrpm_pkg::TH_PGLO_SEL] ?
			polrpm_pkg::PG_LO_ALT_PCT : polrpm_pkg::PG_LO_PCT);
	end

	// Warnings feed status, alert and the restart check in go_on, never these terms
	assign evt[polrpm_pkg::SB_OV] = state != polrpm_pkg::S_OFF && state != polrpm_pkg::S_WAIT &&
		armed && ov_hi;
	assign evt[polrpm_pkg::SB_OC] = state == polrpm_pkg::S_ON && armed && ilim && uv_low;
	assign evt[polrpm_pkg::SB_TR] = ramp_up && !fm[polrpm_pkg::FM_TR_DIS] &&
		diff > polrpm_pkg::TRACK_CODES;
	assign evt[polrpm_pkg::SB_UV] = steady && uv_low && !evt[polrpm_pkg::SB_OC];
	assign evt[polrpm_pkg::SB_OT] = state == polrpm_pkg::S_ON && ot_hot;
	assign fast = |{evt[polrpm_pkg::SB_OV], evt[polrpm_pkg::SB_OC], evt[polrpm_pkg::SB_TR],
		err_s && state != polrpm_pkg::S_OFF && state != polrpm_pkg::S_WAIT};
	assign regular = state == polrpm_pkg::S_ON && !fast && (evt[polrpm_pkg::SB_UV] ||
		evt[polrpm_pkg::SB_OT] || prop_ext);
	assign latch_hit = |(evt & fm[6:2]);
	assign hic_done = hic_cnt == HICCUP;
	assign go_on = run && (state == polrpm_pkg::S_OFF || (state == polrpm_pkg::S_WAIT &&
		hic_done && (latched ? (&stat[6:2] && !ot_hot) :
		(stat[polrpm_pkg::SB_OT] || !otw_hot))));

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state <= polrpm_pkg::S_OFF;
			by_fault <= 1'h0;
			latched <= 1'h0;
		end else begin
			case (state)
				polrpm_pkg::S_OFF: begin
					latched <= 1'h0;
					if (go_on)
						state <= polrpm_pkg::S_ON;
				end
				polrpm_pkg::S_ON: begin
					if (fast) begin
						state <= polrpm_pkg::S_WAIT;
						latched <= latch_hit;
					end else if (regular) begin
						state <= polrpm_pkg::S_DOWN;
						by_fault <= 1'h1;
						latched <= latch_hit;
					end else if (!run) begin
						state <= polrpm_pkg::S_DOWN;
						by_fault <= 1'h0;
					end
				end
				polrpm_pkg::S_DOWN: begin
					if (fast)
						state <= polrpm_pkg::S_WAIT;
					else if (vref_code == 16'h0000)
						state <= by_fault ? polrpm_pkg::S_WAIT : polrpm_pkg::S_OFF;
				end
				polrpm_pkg::S_WAIT: begin
					if (go_on)
						state <= polrpm_pkg::S_ON;
					else if (hic_done && !run)
						state <= polrpm_pkg::S_OFF;
				end
				default: state <= polrpm_pkg::S_OFF;
			endcase
		end
	end

	// Hiccup interval counted from entry into S_WAIT, after a ramp-down or directly on a fast fault
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			hic_cnt <= 22'h0;
		else if (state != polrpm_pkg::S_WAIT)
			hic_cnt <= 22'h0;
		else if (!hic_done)
			hic_cnt <= hic_cnt + 22'h1;
	end

	// Step timing from master clock edges
	assign cur_div = state == polrpm_pkg::S_DOWN ? slew[31:16] : slew[15:0];
	assign step = tick && (17'(div_cnt) + 17'h1 >= 17'(cur_div));
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			div_cnt <= 16'h0;
		else if (state != polrpm_pkg::S_ON && state != polrpm_pkg::S_DOWN)
			div_cnt <= 16'h0;
		else if (tick)
			div_cnt <= step ? 16'h0 : div_cnt + 16'h1;
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			vref_code <= 16'h0;
		else if (fast)
			vref_code <= 16'h0;
		else if (step && state == polrpm_pkg::S_ON && vref_code < setp)
			vref_code <= vref_code + 16'h1;
		else if (step && state == polrpm_pkg::S_ON && vref_code > setp)
			vref_code <= vref_code - 16'h1;
		else if (step && state == polrpm_pkg::S_DOWN && vref_code != 16'h0)
			vref_code <= vref_code - 16'h1;
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			conv_en <= 1'h0;
			ls_force <= 1'h0;
			prebias <= 16'h0;
		end else begin
			if (fast) begin
				conv_en <= 1'h0;
				ls_force <= evt[polrpm_pkg::SB_OV];
			end else if (go_on) begin
				conv_en <= 1'h1;
				ls_force <= 1'h0;
				prebias <= vo;
			end else if (state == polrpm_pkg::S_DOWN && vref_code == 16'h0) begin
				conv_en <= 1'h0;
			end
		end
	end

	// ****************************************************************
	// Status, power-good and manager signalling
	// ****************************************************************
	logic [6:0] next_stat;
	assign next_stat[polrpm_pkg::SB_OTW] = tmp > polrpm_pkg::OTW_SET_C ? 1'h0 :
		tmp < polrpm_pkg::OTW_CLR_C ? 1'h1 : stat[polrpm_pkg::SB_OTW];
	assign next_stat[polrpm_pkg::SB_PG] = !((steady && pg_bad) || pg_ext);
	genvar gi;
	generate
		for (gi = 2; gi <= 6; gi++) begin : g_fbit
			logic hit, ok_clr;
			assign hit = gi == polrpm_pkg::SB_OT ? ot_hot : evt[gi];
			assign ok_clr = gi == polrpm_pkg::SB_OT ? !ot_hot : 1'h1;
			// Event wins over a clear in the same cycle
			assign next_stat[gi] = hit ? 1'h0 :
				((sw_clr[gi] || go_on) && ok_clr) ? 1'h1 : stat[gi];
		end
	endgenerate

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			stat <= polrpm_pkg::STAT_RST;
		else
			stat <= next_stat;
	end

	logic in_fault;
	assign in_fault = (state == polrpm_pkg::S_DOWN && by_fault) || state == polrpm_pkg::S_WAIT;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pg_oe <= 1'h1;
			pg_o <= 1'h0;
			ok_oe <= 1'h0;
			ok_o <= 1'h0;
			err_out <= 1'h0;
			mgr_alert <= 1'h0;
			oc_limit <= 8'h0;
		end else begin
			pg_oe <= !steady || pg_bad;
			ok_oe <= rep[polrpm_pkg::REP_PROP] && in_fault;
			err_out <= rep[polrpm_pkg::REP_PROP] && ls_force;
			mgr_alert <= (!stat[polrpm_pkg::SB_OTW] && rep[polrpm_pkg::REP_OTW]) ||
				(!stat[polrpm_pkg::SB_PG] && rep[polrpm_pkg::REP_PG]);
			if (!current_limit_setpoint[polrpm_pkg::CLS_COMP_DIS] && tmp > polrpm_pkg::ROOM_C)
				oc_limit <= {1'h0, current_limit_setpoint[6:0]} +
					8'((int'(tmp) - polrpm_pkg::ROOM_C) >>> polrpm_pkg::OC_COMP_SHIFT);
			else
				oc_limit <= {1'h0, current_limit_setpoint[6:0]};
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	step_size_a: assert property (!$stable(vref_code) && vref_code != 16'h0 |->
		(vref_code - $past(vref_code) == 16'h1) || ($past(vref_code) - vref_code == 16'h1))
		else $error("reference moved by more than one step");
	step_tick_a: assert property (!$stable(vref_code) && vref_code != 16'h0 |-> $past(step))
		else $error("reference moved without a divided clock tick");
	hiccup_len_a: assert property ($past(state) == polrpm_pkg::S_WAIT &&
		state == polrpm_pkg::S_ON |-> $past(hic_cnt) == HICCUP)
		else $error("restart before hiccup interval");
	latch_hold_a: assert property (state == polrpm_pkg::S_WAIT && latched &&
		!(&stat[6:2]) |=> state != polrpm_pkg::S_ON)
		else $error("latched protection restarted");
	warn_only_a: assert property (state == polrpm_pkg::S_ON && run && !fast && !regular
		|=> state == polrpm_pkg::S_ON)
		else $error("turned off without a fault");
	ot_warn_a: assert property (tmp > polrpm_pkg::OTW_SET_C |=> !stat[polrpm_pkg::SB_OTW])
		else $error("overtemperature warning bit not low");
	pg_trans_a: assert property (!steady |=> pg_oe)
		else $error("power-good released during transition");
	oc_fast_a: assert property (evt[polrpm_pkg::SB_OC] && !evt[polrpm_pkg::SB_OV] |=>
		!conv_en && !ls_force && !stat[polrpm_pkg::SB_OC])
		else $error("overcurrent did not open both switches");
	uv_reg_a: assert property (evt[polrpm_pkg::SB_UV] && !fast |=>
		state == polrpm_pkg::S_DOWN && conv_en ##1 !stat[polrpm_pkg::SB_UV])
		else $error("undervoltage did not ramp down");
	trk_trip_a: assert property (evt[polrpm_pkg::SB_TR] |=>
		!conv_en && state == polrpm_pkg::S_WAIT)
		else $error("tracking error did not trip");
	ov_trip_a: assert property (evt[polrpm_pkg::SB_OV] |=> (ls_force && !conv_en) [*2])
		else $error("overvoltage did not force low side");

	restart_c: cover property (state == polrpm_pkg::S_WAIT ##1 state == polrpm_pkg::S_ON);
	regular_off_c: cover property (state == polrpm_pkg::S_DOWN ##1 state == polrpm_pkg::S_WAIT);
	ov_c: cover property (evt[polrpm_pkg::SB_OV]);
	steady_c: cover property (steady && !pg_oe);
endmodule : polrpm_top

// File: dv/polrpm_mgr.sv
/*
 * Power manager and output stage model for the ramp and protection manager.
 * Assumes the bench selects the output behaviour and any external pull on power-good.
 */
`timescale 1ns/1ns
module polrpm_mgr (
	input wire logic [15:0] vref_code,
	input wire logic [1:0] mode,
	input wire logic pg_oe,
	input wire logic ok_oe,
	input wire logic pg_pull,
	output logic mclk_in,
	output logic [15:0] vout_code,
	output logic pg_in,
	output logic ok_in
);
	// ****
	// Free-running master clock
	// ****
	initial begin
		mclk_in = 1'b0;
		forever #155 mclk_in = ~mclk_in;
	end
	// Output follows, sags to half, stays at zero or overshoots by a quarter
	always_comb begin
		case (mode)
			2'd1: vout_code = vref_code >> 1;
			2'd2: vout_code = 16'h0000;
			2'd3: vout_code = vref_code + (vref_code >> 2);
			default: vout_code = vref_code;
		endcase
	end
	assign pg_in = ~(pg_oe | pg_pull);
	assign ok_in = ~ok_oe;
endmodule : polrpm_mgr

// File: dv/polrpm_tb_top.sv
/*
 * Self-checking bench of the ramp and protection manager.
 * Assumes the manager model in polrpm_mgr and a short restart interval.
 */
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
	$display("unexpected %s exp %h got %h", n, e, g); end end
module polrpm_tb_top;
	logic sys_clk, resetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, mclk_in, pg_in, pg_o, pg_oe, ok_in, ok_o, ok_oe;
	logic mgr_alert, conv_en, ls_force, pg_pull, ilim, err_out;
	logic pc = 1'b0;
	logic [7:0] awaddr, araddr, temp_c, oc_limit;
	logic [31:0] wdata, rdata, rd, xs_st;
	logic [1:0] bresp, rresp, rsp, mode;
	logic [15:0] vout_code, vref_code, sp, tv;
	logic [15:0] pv = 16'h0000;
	int n_fail, checks_done, n;
	int cyc = 0;
	polrpm_top #(.HICCUP(22'd50)) DUT (.sys_clk(sys_clk), .resetn(resetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .vout_code(vout_code), .temp_c(temp_c), .ilim_active(ilim),
		.mclk_in(mclk_in), .pg_in(pg_in), .pg_o(pg_o), .pg_oe(pg_oe), .ok_in(ok_in), .ok_o(ok_o),
		.ok_oe(ok_oe), .err_in(1'b0), .err_out(err_out), .mgr_alert(mgr_alert),
		.vref_code(vref_code), .conv_en(conv_en), .ls_force(ls_force), .oc_limit(oc_limit));
	polrpm_mgr mgr (.vref_code(vref_code), .mode(mode), .pg_oe(pg_oe), .ok_oe(ok_oe),
		.pg_pull(pg_pull), .mclk_in(mclk_in), .vout_code(vout_code), .pg_in(pg_in), .ok_in(ok_in));
	// ****
	// Helpers
	// ****
	function automatic logic [31:0] xs();
		xs_st = xs_st ^ (xs_st << 13);
		xs_st = xs_st ^ (xs_st >> 17);
		xs_st = xs_st ^ (xs_st << 5);
		return xs_st;
	endfunction : xs
	function automatic logic [15:0] trk();
		return polrpm_pkg::TRACK_CODES + 16'd1;
	endfunction : trk
	function automatic logic [7:0] oc_exp(input int t);
		return 8'(polrpm_pkg::CLS_RST) + 8'((t - polrpm_pkg::ROOM_C) >>> polrpm_pkg::OC_COMP_SHIFT);
	endfunction : oc_exp
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : final_report
	task automatic wr(input logic [5:0] i, input logic [31:0] d);
		@(posedge sys_clk);
		awaddr <= {i, 2'b00};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		rsp = bresp;
		bready <= 1'b0;
	endtask : wr
	task automatic rdr(input logic [5:0] i);
		@(posedge sys_clk);
		araddr <= {i, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rd = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask : rdr
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (resetn && pc && conv_en && vref_code !== pv) begin
			`CHK("ramp_step", 16'h0001, ((vref_code > pv) ? vref_code - pv : pv - vref_code))
		end
		pv <= vref_code;
		pc <= conv_en;
		if (cyc == 20000) begin
			n_fail++;
			final_report();
		end
	end
	// ****
	// Main sequence
	// ****
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, pg_pull, ilim} = '0;
		{awaddr, araddr, wdata, mode, n_fail, checks_done} = '0;
		temp_c = 8'd25;
		xs_st = 32'd67;
		resetn = 1'b0;
		repeat (5) @(posedge sys_clk);
		resetn <= 1'b1;
		rdr(polrpm_pkg::IDX_THR);
		`CHK("thr_rst", polrpm_pkg::TH_RST, rd)
		rdr(polrpm_pkg::IDX_SLEW);
		`CHK("slew_rst", polrpm_pkg::SLEW_RST, rd)
		rdr(polrpm_pkg::IDX_STAT);
		`CHK("stat_rst", {25'h0, polrpm_pkg::STAT_RST}, rd)
		rdr(6'h0F);
		`CHK("rd_unmapped", polrpm_pkg::RESP_SLVERR, rsp)
		wr(6'h0F, 32'hFFFFFFFF);
		`CHK("wr_unmapped", polrpm_pkg::RESP_SLVERR, rsp)
		sp = 16'h0050 + (16'(xs()) & 16'h001F);
		wr(polrpm_pkg::IDX_SET, {16'h0, sp});
		wr(polrpm_pkg::IDX_RUN, 32'h1);
		while (vref_code !== sp) @(posedge sys_clk);
		repeat (6) @(posedge sys_clk);
		`CHK("pg_steady", 1'b0, pg_oe)
		rdr(polrpm_pkg::IDX_STAT);
		`CHK("pg_bit", 1'b1, rd[polrpm_pkg::SB_PG])
		pg_pull <= 1'b1;
		repeat (6) @(posedge sys_clk);
		rdr(polrpm_pkg::IDX_STAT);
		`CHK("pg_ext", 1'b0, rd[polrpm_pkg::SB_PG])
		pg_pull <= 1'b0;
		temp_c <= 8'd121 + 8'(xs() % 32'd7);
		wr(polrpm_pkg::IDX_REP, 32'h1);
		repeat (6) @(posedge sys_clk);
		rdr(polrpm_pkg::IDX_STAT);
		`CHK("otw_set", 1'b0, rd[polrpm_pkg::SB_OTW])
		`CHK("otw_alert", 1'b1, mgr_alert)
		`CHK("otw_on", 1'b1, conv_en)
		temp_c <= 8'd118;
		repeat (6) @(posedge sys_clk);
		rdr(polrpm_pkg::IDX_STAT);
		`CHK("otw_hyst", 1'b0, rd[polrpm_pkg::SB_OTW])
		temp_c <= 8'd116;
		repeat (6) @(posedge sys_clk);
		rdr(polrpm_pkg::IDX_STAT);
		`CHK("otw_clr", 1'b1, rd[polrpm_pkg::SB_OTW])
		`CHK("oc_comp", oc_exp(116), oc_limit)
		wr(polrpm_pkg::IDX_CLS, 32'hC0);
		repeat (2) @(posedge sys_clk);
		`CHK("oc_nocomp", 8'h40, oc_limit)
		temp_c <= 8'h87;
		repeat (6) @(posedge sys_clk);
		rdr(polrpm_pkg::IDX_STAT);
		`CHK("ot_bit", 1'b0, rd[polrpm_pkg::SB_OT])
		`CHK("ot_ramp", 1'b1, conv_en)
		while (conv_en) @(posedge sys_clk);
		temp_c <= 8'h7D;
		repeat (80) @(posedge sys_clk);
		`CHK("ot_hold", 1'b0, conv_en)
		temp_c <= 8'h77;
		while (!conv_en) @(posedge sys_clk);
		while (vref_code !== sp) @(posedge sys_clk);
		temp_c <= 8'h74;
		repeat (6) @(posedge sys_clk);
		mode <= 2'd1;
		repeat (6) @(posedge sys_clk);
		rdr(polrpm_pkg::IDX_STAT);
		`CHK("uv_bit", 1'b0, rd[polrpm_pkg::SB_UV])
		`CHK("uv_ramp", 1'b1, conv_en)
		while (conv_en) @(posedge sys_clk);
		`CHK("uv_zero", 16'h0000, vref_code)
		mode <= 2'd0;
		n = 0;
		while (!conv_en) begin
			@(posedge sys_clk);
			n++;
		end
		`CHK("hiccup", 1'b1, (n >= 50 && n <= 60))
		while (vref_code !== sp) @(posedge sys_clk);
		wr(polrpm_pkg::IDX_FMODE, 32'h40);
		mode <= 2'd3;
		repeat (6) @(posedge sys_clk);
		`CHK("ov_off", 1'b0, conv_en)
		`CHK("ov_ls", 1'b1, ls_force)
		rdr(polrpm_pkg::IDX_STAT);
		`CHK("ov_bit", 1'b0, rd[polrpm_pkg::SB_OV])
		mode <= 2'd0;
		repeat (120) @(posedge sys_clk);
		`CHK("ov_latch", 1'b0, conv_en)
		rdr(polrpm_pkg::IDX_STAT);
		`CHK("ov_hold", 1'b0, rd[polrpm_pkg::SB_OV])
		mode <= 2'd2;
		wr(polrpm_pkg::IDX_FMODE, 32'h0);
		wr(polrpm_pkg::IDX_STAT, 32'h7F);
		while (!conv_en) @(posedge sys_clk);
		while (conv_en) begin
			tv = vref_code;
			@(posedge sys_clk);
		end
		`CHK("tr_ref", 1'b1, (tv >= trk() && tv <= trk() + 16'd2))
		`CHK("tr_ls", 1'b0, ls_force)
		rdr(polrpm_pkg::IDX_STAT);
		`CHK("tr_bit", 1'b0, rd[polrpm_pkg::SB_TR])
		wr(polrpm_pkg::IDX_FMODE, 32'h80);
		while (!conv_en) @(posedge sys_clk);
		while (vref_code < 16'd30) @(posedge sys_clk);
		`CHK("tr_dis", 1'b1, conv_en)
		wr(polrpm_pkg::IDX_REP, 32'h5);
		mode <= 2'd1;
		ilim <= 1'b1;
		repeat (6) @(posedge sys_clk);
		`CHK("oc_off", 1'b0, conv_en)
		`CHK("oc_ls", 1'b0, ls_force)
		`CHK("prop_ok", 1'b1, ok_oe)
		`CHK("prop_err", 1'b0, err_out)
		rdr(polrpm_pkg::IDX_STAT);
		`CHK("oc_bit", 1'b0, rd[polrpm_pkg::SB_OC])
		final_report();
	end
endmodule : polrpm_tb_top
